/* logic/ebm_pkg.sv */
`default_nettype none
package ebm_pkg;
  // register byte offsets
  localparam logic [3:0] EBM_CTRL_OFS   = 4'h0;
  localparam logic [3:0] EBM_STATUS_OFS = 4'h4;
  // control field positions
  localparam int EBM_CTRL_MODE_A_LSB = 0;
  localparam int EBM_CTRL_MODE_B_LSB = 2;
  localparam int EBM_CTRL_OREG_A     = 4;
  localparam int EBM_CTRL_OREG_B     = 5;
  localparam int EBM_CTRL_ASYNC      = 6;
  localparam int EBM_CTRL_USED_W     = 7;
  localparam logic [6:0] EBM_CTRL_RST = 7'h00;
  // status field positions
  localparam int EBM_STAT_RBW_OK  = 0;
  localparam int EBM_STAT_RST_LSB = 1;
  // widths that allow the read-before-write option
  localparam int EBM_RBW_W0 = 9;
  localparam int EBM_RBW_W1 = 18;
  localparam int EBM_RBW_W2 = 36;
  localparam int EBM_PORTS  = 2;

  typedef enum logic [1:0] {
    EBM_WR_NORMAL,
    EBM_WR_THROUGH,
    EBM_WR_RBW
  } ebm_mode_t;
endpackage
`default_nettype wire

/* logic/ebm_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ebm_port_if #(
  parameter int AW = 10,
  parameter int DW = 18
);
  logic          en;
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [1:0]    mode;
  logic          oreg;
  logic          async_rst;
  logic          rst_local;
  logic [DW-1:0] array_rd;
  logic          en_q;
  logic          we_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] dout;
  logic [DW-1:0] latch;

  modport mem (output en, we, addr, wdata, mode, oreg, async_rst, rst_local, array_rd,
               input en_q, we_q, addr_q, wdata_q, dout, latch);
  modport port (input en, we, addr, wdata, mode, oreg, async_rst, rst_local, array_rd,
                output en_q, we_q, addr_q, wdata_q, dout, latch);
endinterface
`default_nettype wire

/* logic/ebm_port.sv */
`timescale 1ns/1ps
`default_nettype none
module ebm_port
  import ebm_pkg::*;
#(
  parameter int AW     = 10,
  parameter int DW     = 18,
  parameter bit RBW_OK = 1'b1
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clk_en,
  ebm_port_if.port  p
);
  typedef struct packed {
    logic          en_q;
    logic          we_q;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] wdata_q;
    logic [DW-1:0] latch_q;
    logic [DW-1:0] out_q;
  } ebm_port_st_t;

  ebm_port_st_t s_q;
  ebm_port_st_t s_d;
  ebm_mode_t    mode;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    mode = ebm_mode_t'(p.mode);
    s_d = s_q;
    s_d.en_q    = p.en;                         // (R1)
    s_d.we_q    = p.en & p.we;                  // (R1)
    s_d.addr_q  = p.addr;                       // (R1)
    s_d.wdata_q = p.wdata;                      // (R1)
    if (p.rst_local) begin
      s_d.latch_q = '0;                         // (R7) (R10)
    end else if (s_q.en_q) begin
      if (!s_q.we_q) begin
        s_d.latch_q = p.array_rd;
      end else begin
        case (mode)                             // (R3)
          EBM_WR_THROUGH: s_d.latch_q = s_q.wdata_q;       // (R5)
          // rbw falls back to normal at widths that lack it
          EBM_WR_RBW: s_d.latch_q = RBW_OK ? p.array_rd : s_q.latch_q;  // (R6)
          default: s_d.latch_q = s_q.latch_q;   // (R4)
        endcase
      end
    end
    s_d.out_q = p.rst_local ? '0 : s_q.latch_q; // (R2) (R10)
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // async mode clears at once, without waiting for an enabled edge
  assign p.dout    = (p.async_rst && p.rst_local) ? '0 :
                     (p.oreg ? s_q.out_q : s_q.latch_q);   // (R2) (R7)
  assign p.en_q    = s_q.en_q;
  assign p.we_q    = s_q.we_q;
  assign p.addr_q  = s_q.addr_q;
  assign p.wdata_q = s_q.wdata_q;
  assign p.latch   = s_q.latch_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_INPUT_REG: assert property (clk_en |=> s_q.addr_q == $past(p.addr) && s_q.wdata_q == $past(p.wdata)) // (R1)
    else $error("port input not registered");
  AST_NORMAL_HOLD: assert property (clk_en && s_q.we_q && !p.rst_local && (p.mode == 2'h0 ||
      (p.mode == 2'h2 && !RBW_OK)) |=> $stable(s_q.latch_q)) // (R4)
    else $error("normal write changed output");
  AST_WRITE_THRU: assert property (clk_en && s_q.we_q && !p.rst_local && p.mode == 2'h1
      |=> s_q.latch_q == $past(s_q.wdata_q)) // (R5)
    else $error("write-through data missing");
  AST_RBW_OLD: assert property (clk_en && s_q.we_q && !p.rst_local && p.mode == 2'h2 && RBW_OK
      |=> s_q.latch_q == $past(p.array_rd)) // (R6)
    else $error("read-before-write old data missing");
  AST_OREG_STAGE: assert property (clk_en && !p.rst_local |=> s_q.out_q == $past(s_q.latch_q)) // (R2)
    else $error("output register stage wrong");
  AST_RESET_ZERO: assert property (clk_en && p.rst_local ##1 !p.oreg |-> p.dout == '0) // (R10)
    else $error("reset did not clear output");
  AST_ASYNC_CLEAR: assert property (p.async_rst && p.rst_local |-> p.dout == '0) // (R7)
    else $error("async reset did not clear output");

  COV_WT:  cover property (clk_en && s_q.we_q && p.mode == 2'h1);
  COV_RBW: cover property (clk_en && s_q.we_q && p.mode == 2'h2);
  COV_RST: cover property (p.rst_local && p.oreg);
endmodule
`default_nettype wire

/* logic/ebm_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) each port registers write data and address before the array uses them
// (R2) per-port option adds output register; otherwise latch drives output directly
// (R3) write behaviour option applies per port, single or dual port use
// (R4) normal mode: output updates only on reads, not during writes
// (R5) write-through mode: written data appears on that port's output
// (R6) read-before-write shows old contents; only at widths 9, 18, 36
// (R7) output latches resettable; async or clocked reset selectable
// (R8) each port's local reset clears only that port's output
// (R9) global reset clears both ports' output latches
// (R10) latch reset forces output to zero, array contents untouched
module ebm_top
  import ebm_pkg::*;
#(
  parameter int AW = 10,
  parameter int DW = 18
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          a_en,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [DW-1:0] a_wdata,
  output logic      [DW-1:0] a_rdata,
  input  wire logic          b_en,
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [DW-1:0] b_wdata,
  output logic      [DW-1:0] b_rdata,
  input  wire logic          port_a_output_reset,
  input  wire logic          port_b_output_reset,
  input  wire logic          global_reset_active_low
);
  localparam bit RBW_OK = (DW == EBM_RBW_W0) || (DW == EBM_RBW_W1) || (DW == EBM_RBW_W2);

  typedef struct packed {
    logic [EBM_CTRL_USED_W-1:0] ctrl_q;
    logic                       ack_q;
    logic [31:0]                rdata_q;
    logic                       gsync1_q;
    logic                       gsync2_q;
  } ebm_top_st_t;

  ebm_top_st_t s_q;
  ebm_top_st_t s_d;
  logic [DW-1:0] mem [2**AW];
  logic [EBM_PORTS-1:0]         p_en;
  logic [EBM_PORTS-1:0]         p_we;
  logic [EBM_PORTS-1:0][AW-1:0] p_addr;
  logic [EBM_PORTS-1:0][DW-1:0] p_wdata;
  logic [EBM_PORTS-1:0]         p_lrst;
  logic [EBM_PORTS-1:0]         p_oreg;
  logic [EBM_PORTS-1:0][1:0]    p_mode;
  logic [EBM_PORTS-1:0]         p_rst;
  logic [EBM_PORTS-1:0]         q_we;
  logic [EBM_PORTS-1:0][AW-1:0] q_addr;
  logic [EBM_PORTS-1:0][DW-1:0] q_wdata;
  logic [EBM_PORTS-1:0][DW-1:0] q_dout;
  logic [EBM_PORTS-1:0][DW-1:0] q_latch;
  logic [EBM_PORTS-1:0]         q_en;
  logic                         glob_rst;
  logic                         req;

  ////////////////////////////////////////////////////////////////////////
  // global reset pin comes from outside this clock, so synchronise it
  assign glob_rst = s_q.gsync2_q;
  assign req      = avs_read | avs_write;

  always_comb begin
    s_d = s_q;
    s_d.gsync1_q = ~global_reset_active_low;
    s_d.gsync2_q = s_q.gsync1_q;
    s_d.ack_q    = req & ~s_q.ack_q;
    // a write lands only at the edge where the master sees waitrequest low
    if (avs_write && s_q.ack_q && avs_address == EBM_CTRL_OFS) begin
      s_d.ctrl_q = avs_writedata[EBM_CTRL_USED_W-1:0];
    end
    if (req && !s_q.ack_q) begin
      s_d.rdata_q = 32'h0000_0000;
      if (avs_read && avs_address == EBM_CTRL_OFS) begin
        s_d.rdata_q[EBM_CTRL_USED_W-1:0] = s_q.ctrl_q;
      end
      if (avs_read && avs_address == EBM_STATUS_OFS) begin
        s_d.rdata_q[EBM_STAT_RBW_OK]                    = RBW_OK;
        s_d.rdata_q[EBM_STAT_RST_LSB +: EBM_PORTS]      = p_rst;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{ctrl_q: EBM_CTRL_RST, rdata_q: 32'h0000_0000, default: 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // one wait cycle, then the answer stands for the sampling edge
  assign avs_waitrequest = req & ~s_q.ack_q;
  assign avs_readdata    = s_q.rdata_q;

  ////////////////////////////////////////////////////////////////////////
  assign p_en    = {b_en, a_en};
  assign p_we    = {b_we, a_we};
  assign p_addr  = {b_addr, a_addr};
  assign p_wdata = {b_wdata, a_wdata};
  assign p_lrst  = {port_b_output_reset, port_a_output_reset};
  assign p_oreg  = {s_q.ctrl_q[EBM_CTRL_OREG_B], s_q.ctrl_q[EBM_CTRL_OREG_A]};
  assign p_mode  = {s_q.ctrl_q[EBM_CTRL_MODE_B_LSB +: 2], s_q.ctrl_q[EBM_CTRL_MODE_A_LSB +: 2]};
  assign p_rst   = p_lrst | {EBM_PORTS{glob_rst}};   // (R8) (R9)

  genvar gi;
  generate
    for (gi = 0; gi < EBM_PORTS; gi++) begin : g_port   // (R3)
      ebm_port_if #(.AW(AW), .DW(DW)) pif ();
      assign pif.en        = p_en[gi];
      assign pif.we        = p_we[gi];
      assign pif.addr      = p_addr[gi];
      assign pif.wdata     = p_wdata[gi];
      assign pif.mode      = p_mode[gi];
      assign pif.oreg      = p_oreg[gi];
      assign pif.async_rst = s_q.ctrl_q[EBM_CTRL_ASYNC];
      assign pif.rst_local = p_rst[gi];
      assign pif.array_rd  = mem[pif.addr_q];
      assign q_we[gi]      = pif.we_q;
      assign q_en[gi]      = pif.en_q;
      assign q_addr[gi]    = pif.addr_q;
      assign q_wdata[gi]   = pif.wdata_q;
      assign q_dout[gi]    = pif.dout;
      assign q_latch[gi]   = pif.latch;
      ebm_port #(.AW(AW), .DW(DW), .RBW_OK(RBW_OK)) u_port (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .p      (pif.port)
      );
    end
  endgenerate

  // array takes registered inputs only; port a wins an address collision.
  // no reset here: latch resets never touch contents
  always_ff @(posedge clock) begin
    if (clk_en) begin
      for (int i = EBM_PORTS - 1; i >= 0; i--) begin
        if (q_we[i]) begin
          mem[q_addr[i]] <= q_wdata[i];   // (R1) (R10)
        end
      end
    end
  end

  assign a_rdata = q_dout[0];
  assign b_rdata = q_dout[1];

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_LOCAL_A_ONLY: assert property (port_a_output_reset && !p_rst[1] && clk_en && !q_en[1] // (R8)
      |=> $stable(q_latch[1]))
    else $error("port a reset disturbed port b");
  AST_LOCAL_B_ONLY: assert property (port_b_output_reset && !p_rst[0] && clk_en && !q_en[0] // (R8)
      |=> $stable(q_latch[0]))
    else $error("port b reset disturbed port a");
  AST_LOCAL_ISOLATE_A: assert property (!port_a_output_reset && !glob_rst |-> !p_rst[0]) // (R8)
    else $error("port a reset without cause");
  AST_LOCAL_ISOLATE: assert property (!port_b_output_reset && !glob_rst |-> !p_rst[1]) // (R8)
    else $error("port b reset without cause");
  // two enabled edges through the synchroniser, a third to clear
  AST_GLOBAL_SYNC: assert property (!global_reset_active_low && clk_en ##1 clk_en |=> glob_rst) // (R9)
    else $error("global reset not synchronised");
  AST_GLOBAL_BOTH: assert property (!global_reset_active_low && clk_en ##1 clk_en ##1 clk_en // (R9)
      |=> q_latch[0] == '0 && q_latch[1] == '0)
    else $error("global reset did not clear both ports");
  AST_ASYNC_A: assert property (s_q.ctrl_q[EBM_CTRL_ASYNC] && p_rst[0] |-> a_rdata == '0) // (R7)
    else $error("async reset left port a output");
  AST_ASYNC_B: assert property (s_q.ctrl_q[EBM_CTRL_ASYNC] && p_rst[1] |-> b_rdata == '0) // (R7)
    else $error("async reset left port b output");
  AST_LATCH_DIRECT: assert property (!s_q.ctrl_q[EBM_CTRL_ASYNC] && !p_oreg[0] |-> a_rdata == q_latch[0]) // (R2)
    else $error("latch not driving port a");

  // port a wins a same-address collision, so b is not checked when both write one address
  AST_ARRAY_WRITE_A: assert property (q_we[0] && clk_en // (R1)
      |=> mem[$past(q_addr[0])] == $past(q_wdata[0]))
    else $error("port a write missing in array");
  AST_ARRAY_WRITE_B: assert property (q_we[1] && clk_en && !(q_we[0] && q_addr[0] == q_addr[1]) // (R1)
      |=> mem[$past(q_addr[1])] == $past(q_wdata[1]))
    else $error("port b write missing in array");
  AST_CTRL_LANDS: assert property (avs_write && !avs_waitrequest && avs_address == EBM_CTRL_OFS && clk_en // (R3)
      |=> s_q.ctrl_q == $past(avs_writedata[EBM_CTRL_USED_W-1:0]))
    else $error("control write lost");
  AST_STATUS_READ: assert property (avs_read && !avs_waitrequest && avs_address == EBM_STATUS_OFS // (R8)
      && $past(clk_en) |-> avs_readdata[EBM_STAT_RST_LSB +: EBM_PORTS] == $past(p_rst)
      && avs_readdata[EBM_STAT_RBW_OK] == RBW_OK)
    else $error("status read wrong");
  AST_BUS_ONE_WAIT: assert property (req && !s_q.ack_q && clk_en |=> !avs_waitrequest || !req) // (R2)
    else $error("bus answer late");

  COV_GLOBAL: cover property (glob_rst && clk_en);
  COV_BUS_WR: cover property (avs_write && !avs_waitrequest);
endmodule
`default_nettype wire

/* verification/ebm_user_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ebm_user_model #(
  parameter int AW = 10,
  parameter int DW = 18
) (
  input  wire logic          clock,
  output logic               en,
  output logic               we,
  output logic      [AW-1:0] addr,
  output logic      [DW-1:0] wdata,
  output logic               out_reset
);
  initial begin
    en = 1'h0;
    we = 1'h0;
    addr = '0;
    wdata = '0;
    out_reset = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // held through the capture edge; released address and data carry the inverse
  task automatic access(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    en <= 1'h1;
    we <= w;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    en <= 1'h0;
    we <= 1'h0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // own reset only, the other port is left alone
  task automatic pulse_reset(input int n);
    @(posedge clock);
    out_reset <= 1'h1;
    repeat (n) @(posedge clock);
    out_reset <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* verification/ebm_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ebm_top_tb;
  import ebm_pkg::*;
  localparam int AW = 10;
  localparam int DW = 18;
  logic          clock, rst, clk_en, avs_read, avs_write, avs_waitrequest;
  logic [3:0]    avs_address;
  logic [31:0]   avs_writedata, avs_readdata, rd;
  logic          a_en, a_we, b_en, b_we, global_reset_active_low;
  logic          port_a_output_reset, port_b_output_reset;
  logic [AW-1:0] a_addr, b_addr;
  logic [DW-1:0] a_wdata, b_wdata, a_rdata, b_rdata, nw, ex;
  int            miscompares, samples_checked;
  int            cycles = 0;
  ebm_top #(.AW(AW), .DW(DW)) uut (.clock, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .a_en, .a_we, .a_addr, .a_wdata, .a_rdata,
    .b_en, .b_we, .b_addr, .b_wdata, .b_rdata, .port_a_output_reset, .port_b_output_reset,
    .global_reset_active_low);
  ebm_user_model #(.AW(AW), .DW(DW)) um_a (.clock, .en(a_en), .we(a_we), .addr(a_addr),
    .wdata(a_wdata), .out_reset(port_a_output_reset));
  ebm_user_model #(.AW(AW), .DW(DW)) um_b (.clock, .en(b_en), .we(b_we), .addr(b_addr),
    .wdata(b_wdata), .out_reset(port_b_output_reset));
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a stuck handshake ends here, never hangs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      test_done;
    end
  end
  task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t bus got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_port(input logic [DW-1:0] g, input logic [DW-1:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t port got %h exp %h", $time, g, e);
    end
  endtask
  // request held until the edge that samples waitrequest low; data taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clock);
    while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    samples_checked = 0;
    rst = 1'h1;
    clk_en = 1'h1;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    global_reset_active_low = 1'h1;
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    bus(0, EBM_CTRL_OFS, 0);
    chk_bus(rd, 32'(EBM_CTRL_RST));
    bus(0, EBM_STATUS_OFS, 0);
    chk_bus(rd, 32'h0000_0001);
    bus(1, EBM_CTRL_OFS, 32'hFFFF_FFC6);
    bus(0, EBM_CTRL_OFS, 0);
    chk_bus(rd, 32'h0000_0046);
    bus(1, 4'h8, 32'hFFFF_FFFF);
    bus(0, 4'h8, 0);
    chk_bus(rd, 32'h0000_0000);
    // port a walks every mode code with and without output stage, b stays write-through
    for (int m = 0; m < 4; m++) begin
      for (int o = 0; o < 2; o++) begin
        nw = 18'h0_3330 + 18'(2 * m + o);
        ex = (m == 1) ? nw : (m == 2) ? 18'h0_2222 : 18'h0_1111;
        bus(1, EBM_CTRL_OFS, 32'(m + 4 + 16 * o));
        um_b.access(1, 10'h001, 18'h0_1111);
        um_b.access(1, 10'h002, 18'h0_2222);
        um_a.access(0, 10'h001, '0);
        repeat (2) @(posedge clock);
        um_a.access(1, 10'h002, nw);
        @(posedge clock);
        #1;
        chk_port(a_rdata, o ? 18'h0_1111 : ex);
        @(posedge clock);
        #1;
        chk_port(a_rdata, ex);
        chk_port(b_rdata, 18'h0_2222);
        um_a.access(0, 10'h002, '0);
        repeat (1 + o) @(posedge clock);
        #1;
        chk_port(a_rdata, nw);
      end
    end
    bus(1, EBM_CTRL_OFS, 0);
    um_a.pulse_reset(1);
    #1;
    chk_port(a_rdata, '0);
    chk_port(b_rdata, 18'h0_2222);
    um_a.access(0, 10'h002, '0);
    @(posedge clock);
    #1;
    chk_port(a_rdata, nw);
    // async masking must not wait for an edge
    bus(1, EBM_CTRL_OFS, 32'h0000_0040);
    fork
      um_b.pulse_reset(4);
      begin
        @(posedge clock);
        #1;
        chk_port(b_rdata, '0);
        bus(0, EBM_STATUS_OFS, 0);
        chk_bus(rd, 32'h0000_0005);
      end
    join
    bus(1, EBM_CTRL_OFS, 0);
    um_b.access(0, 10'h001, '0);
    @(posedge clock);
    global_reset_active_low <= 1'h0;
    #1;
    chk_port(b_rdata, 18'h0_1111);
    repeat (4) @(posedge clock);
    #1;
    chk_port(a_rdata, '0);
    chk_port(b_rdata, '0);
    @(posedge clock);
    global_reset_active_low <= 1'h1;
    test_done;
  end
endmodule
`default_nettype wire
